// [sim/vectored_priority_interrupts_tb.sv]
// self-checking bench for the vectored priority interrupt controller
// assumes: vpi_core_model acks offers; sources hold requests until acked
`timescale 1ns/1ps
module vectored_priority_interrupts_tb
  import vpi_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic [47:0] req = '0;
  vpi_level_t  core_min_level = 2'h0;
  logic        level_wr_en = 1'b0;
  vpi_vector_t level_wr_vector = 6'h00;
  vpi_level_t  level_wr_level = 2'h0;
  logic        base_wr_en = 1'b0;
  logic [20:0] base_wr_data = 21'h000000;
  logic [3:0]  ack_delay = 4'h1;
  logic        irq_ack;
  logic        irq_request;
  vpi_vector_t irq_vector_reg;
  vpi_level_t  irq_level_reg;
  logic [20:0] fetch_addr_reg;
  logic [20:0] vector_base_register;
  logic [20:0] base_exp = 21'h000000;
  logic [1:0]  lvl_exp [48];
  logic [1:0]  table_op [48];
  int          err_total = 0;
  int          check_count = 0;
  int          cyc = 0;

  always #10 clk_sys = ~clk_sys;

  // request bits are indexed by vector number; reserved bits stay unwired
  vpi_controller uut (
    .clk_sys                  (clk_sys),
    .reset                    (reset),
    .core_exception_req       (req[5:2]),
    .debug_req                ({req[11:9], req[7:6]}),
    .soft_int_req             ({req[14], req[15], req[16]}),
    .external_request_a       (req[17]),
    .external_request_b       (req[18]),
    .low_voltage_detector     (req[20]),
    .clock_synth_req          (req[21]),
    .flash_module_req         (req[24:22]),
    .can_req                  (req[29:26]),
    .gpio_req                 ({req[30], req[31], req[32], req[33], req[34], req[35]}),
    .spi_channel_1_req        (req[39:38]),
    .spi_channel_0_req        (req[41:40]),
    .serial_channel_1_req     ({req[46:45], req[43:42]}),
    .quadrature_decoder_1_req (req[47]),
    .core_min_level           (core_min_level),
    .level_wr_en              (level_wr_en),
    .level_wr_vector          (level_wr_vector),
    .level_wr_level           (level_wr_level),
    .base_wr_en               (base_wr_en),
    .base_wr_data             (base_wr_data),
    .irq_ack                  (irq_ack),
    .irq_request              (irq_request),
    .irq_vector_reg           (irq_vector_reg),
    .irq_level_reg            (irq_level_reg),
    .fetch_addr_reg           (fetch_addr_reg),
    .vector_base_register     (vector_base_register)
  );

  vpi_core_model core (
    .clk_sys     (clk_sys),
    .reset       (reset),
    .irq_request (irq_request),
    .ack_delay   (ack_delay),
    .irq_ack     (irq_ack)
  );

  task automatic end_sim();
    if (err_total == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // a hung offer loop ends here instead of running forever
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      end_sim();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic bit valid(input int v);
    return v >= 2 && v <= 47 && !(v inside {8, 12, 13, 19, 25, 36, 37, 44});
  endfunction

  // waits for the offer, checks it, then drops the source at the ack edge
  task automatic serve(input int v);
    logic [20:0] f;
    f = base_exp + 21'(2 * v);
    while (irq_request !== 1'b1) begin
      @(posedge clk_sys);
      #1;
    end
    chk("irq_vector_reg", 32'(v), 32'(irq_vector_reg));
    chk("irq_level_reg", 32'(lvl_exp[v]), 32'(irq_level_reg));
    chk("fetch_addr_reg", 32'(f), 32'(fetch_addr_reg));
    chk("table_op", 32'h2, 32'(table_op[int'((fetch_addr_reg - base_exp) >> 1)]));
    while (!(irq_ack === 1'b1 && irq_request === 1'b1)) begin
      @(posedge clk_sys);
      #1;
    end
    @(posedge clk_sys);
    #1;
    req[v] = 1'b0;
  endtask

  // bench copy of the level store: clamps and ignores as the design must
  task automatic wr_level(input int v, input logic [1:0] l);
    @(posedge clk_sys);
    #1;
    level_wr_en = 1'b1;
    level_wr_vector = 6'(v);
    level_wr_level = l;
    @(posedge clk_sys);
    #1;
    level_wr_en = 1'b0;
    if (v inside {6, 7, 9, 10, 11}) begin
      lvl_exp[v] = (l == 2'h0) ? 2'h1 : l;
    end else if (valid(v) && v >= 17) begin
      lvl_exp[v] = (l == 2'h3) ? 2'h2 : l;
    end
  endtask

  task automatic s_sweep();
    for (int v = 0; v < 48; v++) begin
      if (valid(v)) begin
        req[v] = 1'b1;
        serve(v);
      end
    end
  endtask

  task automatic s_program();
    wr_level(11, 2'h3);
    wr_level(7, 2'h0);
    wr_level(46, 2'h3);
    wr_level(40, 2'h2);
    wr_level(26, 2'h1);
    wr_level(5, 2'h0);
    req = 48'h4100044088a0;
    serve(5);
    serve(11);
    serve(40);
    serve(46);
    serve(7);
    serve(15);
    serve(26);
    serve(22);
  endtask

  task automatic s_base();
    @(posedge clk_sys);
    #1;
    base_wr_en = 1'b1;
    base_wr_data = 21'h1ffffa;
    @(posedge clk_sys);
    #1;
    base_wr_en = 1'b0;
    base_exp = 21'h1ffffa;
    chk("vector_base_register", 32'h1ffffa, 32'(vector_base_register));
    req[5] = 1'b1;
    serve(5);
  endtask

  task automatic s_mask_hold();
    core_min_level = 2'h3;
    req[14] = 1'b1;
    repeat (8) @(posedge clk_sys);
    #1;
    chk("irq_request", 32'h0, 32'(irq_request));
    req[2] = 1'b1;
    serve(2);
    core_min_level = 2'h0;
    serve(14);
    ack_delay = 4'h6;
    req[16] = 1'b1;
    while (irq_request !== 1'b1) begin
      @(posedge clk_sys);
      #1;
    end
    req[2] = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    chk("irq_vector_reg", 32'h10, 32'(irq_vector_reg));
    serve(16);
    serve(2);
    ack_delay = 4'h1;
  endtask

  initial begin
    for (int v = 0; v < 48; v++) begin
      lvl_exp[v] = (v <= 5) ? 2'h3 : (v inside {6, 7, 9, 10, 11, 15}) ? 2'h1 :
                   (v == 14) ? 2'h2 : 2'h0;
      // software table: slots 0 and 1 hold a jump (2'h1), the rest a subroutine call (2'h2)
      table_op[v] = (v < 2) ? 2'h1 : 2'h2;
    end
    repeat (16) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    chk("irq_request", 32'h0, 32'(irq_request));
    chk("vector_base_register", 32'h0, 32'(vector_base_register));
    s_sweep();
    req = 48'h00000001c060;
    serve(5);
    serve(14);
    serve(6);
    serve(15);
    serve(16);
    s_program();
    s_base();
    s_mask_hold();
    end_sim();
  end
endmodule

// [sim/vpi_core_model.sv]
// core-side model: takes each interrupt offer after a settable wait
// assumes: one clk_sys domain; ack_delay is held steady during an offer
`timescale 1ns/1ps
module vpi_core_model (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       irq_request,
  input  wire logic [3:0] ack_delay,
  output logic            irq_ack
);
  logic [3:0] wait_reg;

  // one-cycle ack; a longer pulse would take the next offer unseen
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wait_reg <= 4'h0;
      irq_ack  <= 1'b0;
    end else if (irq_request && !irq_ack) begin
      if (wait_reg == ack_delay) begin
        irq_ack  <= 1'b1;
        wait_reg <= 4'h0;
      end else begin
        wait_reg <= wait_reg + 4'h1;
      end
    end else begin
      irq_ack <= 1'b0;
    end
  end
endmodule

// [verilog/vpi_controller.sv]
// vectored priority interrupt controller: arbitrates, offers one vector to the core
// assumes: sources hold requests until the core services them; core acks the offer
`timescale 1ns/1ps
`include "vpi_map.svh"
module vpi_controller
  import vpi_pkg::*;
#(
  parameter int ADDR_W = 21
) (
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic [3:0]        core_exception_req,
  input  wire logic [4:0]        debug_req,
  input  wire logic [2:0]        soft_int_req,
  input  wire logic              external_request_a,
  input  wire logic              external_request_b,
  input  wire logic              low_voltage_detector,
  input  wire logic              clock_synth_req,
  input  wire logic [2:0]        flash_module_req,
  input  wire logic [3:0]        can_req,
  input  wire logic [5:0]        gpio_req,
  input  wire logic [1:0]        spi_channel_1_req,
  input  wire logic [1:0]        spi_channel_0_req,
  input  wire logic [3:0]        serial_channel_1_req,
  input  wire logic              quadrature_decoder_1_req,
  input  wire vpi_level_t        core_min_level,
  input  wire logic              level_wr_en,
  input  wire vpi_vector_t       level_wr_vector,
  input  wire vpi_level_t        level_wr_level,
  input  wire logic              base_wr_en,
  input  wire logic [ADDR_W-1:0] base_wr_data,
  input  wire logic              irq_ack,
  output logic                   irq_request,
  output vpi_vector_t            irq_vector_reg,
  output vpi_level_t             irq_level_reg,
  output logic [ADDR_W-1:0]      fetch_addr_reg,
  output logic [ADDR_W-1:0]      vector_base_register
);

  localparam int N = `VPI_NUM_VECTORS;
  localparam logic [N-1:0] VALID_MASK = `VPI_VALID_MASK;
  localparam logic [N-1:0] FIXED_MASK = `VPI_FIXED_MASK;
  localparam logic [N-1:0] DEBUG_MASK = `VPI_DEBUG_MASK;

  function automatic logic [2*N-1:0] reset_levels();
    logic [2*N-1:0] r;
    r = '0;
    for (int v = 0; v < N; v++) begin
      r[2*v +: 2] = DEBUG_MASK[v] ? `VPI_DEBUG_LVL_RST : `VPI_PERIPH_LVL_RST;
    end
    return r;
  endfunction

  // fixed levels are wired, never stored, so software cannot move them
  function automatic vpi_level_t level_of(input vpi_vector_t v, input logic [2*N-1:0] lv);
    vpi_level_t l;
    l = lv[2*v +: 2];
    if (v >= `VPI_VEC_EXC_LO && v <= `VPI_VEC_EXC_HI) begin
      l = `VPI_EXC_LVL; // RULE7
    end else if (v == `VPI_VEC_SWI2) begin
      l = `VPI_SWI2_LVL; // RULE16
    end else if (v == `VPI_VEC_SWI1) begin
      l = `VPI_SWI1_LVL; // RULE16
    end else if (v == `VPI_VEC_SWI0) begin
      l = `VPI_SWI0_LVL; // RULE16
    end
    return l;
  endfunction

  function automatic vpi_level_t clamp_level(input vpi_vector_t v, input vpi_level_t l);
    vpi_level_t c;
    c = l;
    if (DEBUG_MASK[v]) begin
      if (l < `VPI_DEBUG_LVL_MIN) begin
        c = `VPI_DEBUG_LVL_MIN; // RULE8
      end
    end else if (l > `VPI_PERIPH_LVL_MAX) begin
      c = `VPI_PERIPH_LVL_MAX; // RULE9
    end
    return c;
  endfunction

  function automatic logic [ADDR_W-1:0] entry_addr(input logic [ADDR_W-1:0] base,
                                                   input vpi_vector_t v);
    logic [ADDR_W-1:0] off;
    off = ADDR_W'(v) << `VPI_ENTRY_SHIFT; // RULE14
    return ADDR_W'(base + off); // RULE3
  endfunction

  logic [N-1:0]   req_raw;
  logic [N-1:0]   req_live;
  logic [2*N-1:0] levels_flat;
  logic           mem_wr_en;
  vpi_level_t     mem_wr_level;

  always_comb begin
    req_raw = '0;
    req_raw[`VPI_VEC_EXC_LO +: 4] = core_exception_req; // RULE7
    req_raw[`VPI_VEC_DBG_STEP] = debug_req[0]; // RULE8
    req_raw[`VPI_VEC_DBG_BRK] = debug_req[1]; // RULE8
    req_raw[`VPI_VEC_DBG_TRACE] = debug_req[2]; // RULE8
    req_raw[`VPI_VEC_DBG_TXE] = debug_req[3]; // RULE8
    req_raw[`VPI_VEC_DBG_RXF] = debug_req[4]; // RULE8
    req_raw[`VPI_VEC_SWI2] = soft_int_req[2]; // RULE16
    req_raw[`VPI_VEC_SWI1] = soft_int_req[1]; // RULE16
    req_raw[`VPI_VEC_SWI0] = soft_int_req[0]; // RULE16
    req_raw[`VPI_VEC_EXT_A] = external_request_a; // RULE9
    req_raw[`VPI_VEC_EXT_B] = external_request_b; // RULE9
    req_raw[`VPI_VEC_LOW_VOLT] = low_voltage_detector; // RULE9
    req_raw[`VPI_VEC_CLK_SYNTH] = clock_synth_req;
    req_raw[`VPI_VEC_FLASH_LO +: 3] = flash_module_req; // RULE10
    req_raw[`VPI_VEC_CAN_LO +: 4] = can_req; // RULE11
    // port f takes the lowest vector, so the port bus lands bit-reversed
    req_raw[`VPI_VEC_GPIO_LO +: 6] = {<<{gpio_req}};
    req_raw[`VPI_VEC_SPI_CHANNEL_1_LO +: 2] = spi_channel_1_req; // RULE12
    req_raw[`VPI_VEC_SPI_CHANNEL_0_LO +: 2] = spi_channel_0_req; // RULE12
    req_raw[`VPI_VEC_SERIAL1_LO +: 2] = serial_channel_1_req[1:0]; // RULE13
    req_raw[`VPI_VEC_SERIAL1_HI +: 2] = serial_channel_1_req[3:2]; // RULE13
    req_raw[`VPI_VEC_QDEC1] = quadrature_decoder_1_req;
  end

  // slots 0, 1 and every gap are forced off even if a line is miswired
  assign req_live = req_raw & VALID_MASK; // RULE4 RULE15

  // writes to fixed or reserved slots are dropped
  always_comb begin
    mem_wr_en = level_wr_en && (int'(level_wr_vector) < N) && VALID_MASK[level_wr_vector]
                && !FIXED_MASK[level_wr_vector];
    mem_wr_level = clamp_level(level_wr_vector, level_wr_level); // RULE8 RULE9
  end

  vpi_level_file #(
    .N          (N),
    .RESET_FLAT (96'(reset_levels()))
  ) u_levels (
    .clk_sys     (clk_sys),
    .reset       (reset),
    .wr_en       (mem_wr_en),
    .wr_vector   (level_wr_vector),
    .wr_level    (mem_wr_level),
    .levels_flat (levels_flat)
  );

  logic        win_found;
  vpi_vector_t win_vector;
  vpi_level_t  win_level;

  // scan downward; ">=" lets a lower vector take over on an equal level
  always_comb begin
    win_found = 1'b0;
    win_vector = '0;
    win_level = '0;
    for (int v = N - 1; v >= 0; v--) begin
      if (req_live[v] && (level_of(6'(v), levels_flat) >= core_min_level)) begin
        if (!win_found || (level_of(6'(v), levels_flat) >= win_level)) begin // RULE1 RULE2
          win_found = 1'b1;
          win_vector = 6'(v);
          win_level = level_of(6'(v), levels_flat);
        end
      end
    end
  end

  vpi_state_t        state_reg;
  vpi_state_t        state_next;
  vpi_vector_t       vector_next;
  vpi_level_t        level_next;
  logic [ADDR_W-1:0] fetch_next;
  logic [ADDR_W-1:0] base_reg;
  logic [ADDR_W-1:0] base_next;

  always_comb begin
    state_next = state_reg;
    vector_next = irq_vector_reg;
    level_next = irq_level_reg;
    fetch_next = fetch_addr_reg;
    base_next = base_wr_en ? base_wr_data : base_reg;
    case (state_reg)
      VPI_IDLE: begin
        if (win_found) begin
          state_next = VPI_OFFER;
          vector_next = win_vector;
          level_next = win_level;
          fetch_next = entry_addr(base_reg, win_vector); // RULE3
        end
      end
      VPI_OFFER: begin
        // the offer is frozen until taken so the core never sees it change
        if (irq_ack) begin
          state_next = VPI_IDLE;
        end
      end
      default: begin
        state_next = VPI_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_reg <= VPI_IDLE;
      irq_vector_reg <= '0;
      irq_level_reg <= '0;
      fetch_addr_reg <= '0;
      base_reg <= `VPI_VBA_RST;
    end else begin
      state_reg <= state_next;
      irq_vector_reg <= vector_next;
      irq_level_reg <= level_next;
      fetch_addr_reg <= fetch_next;
      base_reg <= base_next;
    end
  end

  assign irq_request = (state_reg == VPI_OFFER);
  assign vector_base_register = base_reg;

  // checks
  logic [N-1:0]   live_q;
  logic [2*N-1:0] levels_q;
  logic [ADDR_W-1:0] base_q;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      live_q <= '0;
      levels_q <= '0;
      base_q <= '0;
    end else begin
      live_q <= req_live;
      levels_q <= levels_flat;
      base_q <= base_reg;
    end
  end

  logic beaten;
  always_comb begin
    beaten = 1'b0;
    for (int v = 0; v < N; v++) begin
      if (live_q[v] && level_of(6'(v), levels_q) >= core_min_level) begin
        if (level_of(6'(v), levels_q) > irq_level_reg) begin
          beaten = 1'b1;
        end
        if (level_of(6'(v), levels_q) == irq_level_reg && 6'(v) < irq_vector_reg) begin
          beaten = 1'b1;
        end
      end
    end
  end

  a_no_higher_win: assert property (@(posedge clk_sys) disable iff (reset) // RULE1
    $rose(irq_request) |-> !beaten)
    else $error("offered vector lost to a higher or lower-numbered pending request");

  a_offer_level_ok: assert property (@(posedge clk_sys) disable iff (reset) // RULE2
    $rose(irq_request) |-> live_q[irq_vector_reg]
      && irq_level_reg == level_of(irq_vector_reg, levels_q))
    else $error("offered vector was not pending at its level");

  a_fetch_addr: assert property (@(posedge clk_sys) disable iff (reset) // RULE3
    $rose(irq_request) |->
      fetch_addr_reg == ADDR_W'(base_q + (ADDR_W'(irq_vector_reg) << `VPI_ENTRY_SHIFT)))
    else $error("fetch address is not base plus twice the vector");

  a_fetch_even: assert property (@(posedge clk_sys) disable iff (reset) // RULE14
    irq_request |-> fetch_addr_reg[0] == base_q[0] || $stable(fetch_addr_reg))
    else $error("entry offset is not a two-word step");

  a_reset_slots: assert property (@(posedge clk_sys) disable iff (reset) // RULE4
    irq_request |-> irq_vector_reg > `VPI_VEC_WDOG_RST)
    else $error("reset overlay slot offered as interrupt");

  a_reserved_off: assert property (@(posedge clk_sys) disable iff (reset) // RULE15
    irq_request |-> VALID_MASK[irq_vector_reg] && (req_live & ~VALID_MASK) == '0)
    else $error("reserved vector offered");

  a_exc_level: assert property (@(posedge clk_sys) disable iff (reset) // RULE7
    irq_request && irq_vector_reg >= `VPI_VEC_EXC_LO && irq_vector_reg <= `VPI_VEC_EXC_HI
      |-> irq_level_reg == `VPI_EXC_LVL)
    else $error("core exception not at level 3");

  a_debug_range: assert property (@(posedge clk_sys) disable iff (reset) // RULE8
    irq_request && DEBUG_MASK[irq_vector_reg] |-> irq_level_reg >= `VPI_DEBUG_LVL_MIN)
    else $error("debug source below level 1");

  a_periph_range: assert property (@(posedge clk_sys) disable iff (reset) // RULE9
    irq_request && irq_vector_reg > `VPI_VEC_SWI0 |-> irq_level_reg <= `VPI_PERIPH_LVL_MAX)
    else $error("peripheral source above level 2");

  a_swi_level: assert property (@(posedge clk_sys) disable iff (reset) // RULE16
    irq_request && irq_vector_reg == `VPI_VEC_SWI1 |-> irq_level_reg == `VPI_SWI1_LVL)
    else $error("software interrupt 1 not at level 1");

  a_offer_hold: assert property (@(posedge clk_sys) disable iff (reset) // RULE2
    irq_request && !irq_ack |=> irq_request && $stable(irq_vector_reg) && $stable(fetch_addr_reg))
    else $error("offer changed before it was taken");

  c_exception: cover property (@(posedge clk_sys) disable iff (reset)
    $rose(irq_request) && irq_level_reg == `VPI_EXC_LVL);
  c_can_offer: cover property (@(posedge clk_sys) disable iff (reset)
    $rose(irq_request) && irq_vector_reg == `VPI_VEC_CAN_LO);
  c_tie_break: cover property (@(posedge clk_sys) disable iff (reset)
    $rose(irq_request) && $countones(live_q) > 1);
  c_ack_cycle: cover property (@(posedge clk_sys) disable iff (reset)
    irq_request && irq_ack ##2 irq_request);

endmodule

// [verilog/vpi_level_file.sv]
// storage for the programmed priority levels, one entry per vector
// assumes: writes arrive already clamped; all levels read out in parallel from flops
`timescale 1ns/1ps
module vpi_level_file
  import vpi_pkg::*;
#(
  parameter int          N          = 48,
  parameter logic [95:0] RESET_FLAT = '0
) (
  input  wire logic           clk_sys,
  input  wire logic           reset,
  input  wire logic           wr_en,
  input  wire vpi_vector_t    wr_vector,
  input  wire vpi_level_t     wr_level,
  output logic [2*N-1:0]      levels_flat
);

  logic [2*N-1:0] levels_reg;
  logic [2*N-1:0] levels_next;

  always_comb begin
    levels_next = levels_reg;
    if (wr_en && (int'(wr_vector) < N)) begin
      levels_next[2*wr_vector +: 2] = wr_level;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      levels_reg <= RESET_FLAT[2*N-1:0];
    end else begin
      levels_reg <= levels_next;
    end
  end

  assign levels_flat = levels_reg;

endmodule

// [verilog/vpi_map.svh]
// constants for the vectored priority interrupt block
// assumes: one clock domain, sources give level requests held until serviced
// Summary of operation
// (RULE1) A pending request at a higher priority level always wins over any at a lower level.
// (RULE2) Within one priority level the pending request with the smallest vector number wins.
// (RULE3) The handler fetch address is the vector base register plus the vector's table offset.
// (RULE4) Table slots 0 and 1 are reserved for the reset overlays and never act as interrupts.
// (RULE5) Software must put a branch or jump instruction in slots 0 and 1 when they overlay reset.
// (RULE6) Software must put a jump-to-subroutine instruction in every other table slot.
// (RULE7) Core exceptions sit at vectors 2 to 5 with a fixed level of 3.
// (RULE8) Debug sources at vectors 6, 7, 9, 10 and 11 take a programmable level from 1 to 3.
// (RULE9) Sources from vector 17 upward take a programmable level from 0 to 2.
// (RULE10) The flash module raises three separate requests at vectors 22 to 24.
// (RULE11) The CAN controller raises four separate requests at vectors 26 to 29.
// (RULE12) SPI channel 1 uses vectors 38 and 39 and SPI channel 0 uses vectors 40 and 41.
// (RULE13) Serial channel 1 uses vectors 42, 43, 45 and 46, with 44 left unused.
// (RULE14) Each table entry is two words, so the offset is twice the vector number.
// (RULE15) Reserved vector numbers are permanently inactive inputs to the encoder.
// (RULE16) Software interrupts 2, 1 and 0 sit at vectors 14, 15 and 16 with fixed levels 2, 1, 0.
`ifndef VPI_MAP_SVH
`define VPI_MAP_SVH

`define VPI_NUM_VECTORS     48
`define VPI_VALID_MASK      48'hefcffdf7cefc
`define VPI_FIXED_MASK      48'h00000001c03c
`define VPI_DEBUG_MASK      48'h000000000ec0
`define VPI_DEBUG_LVL_MIN   2'h1
`define VPI_DEBUG_LVL_MAX   2'h3
`define VPI_PERIPH_LVL_MIN  2'h0
`define VPI_PERIPH_LVL_MAX  2'h2
`define VPI_DEBUG_LVL_RST   2'h1
`define VPI_PERIPH_LVL_RST  2'h0
`define VPI_EXC_LVL         2'h3
`define VPI_SWI2_LVL        2'h2
`define VPI_SWI1_LVL        2'h1
`define VPI_SWI0_LVL        2'h0
`define VPI_VEC_EXC_LO      6'h02
`define VPI_VEC_EXC_HI      6'h05
`define VPI_VEC_SWI2        6'h0e
`define VPI_VEC_SWI1        6'h0f
`define VPI_VEC_SWI0        6'h10
`define VPI_VEC_FLASH_LO    6'h16
`define VPI_VEC_CAN_LO      6'h1a
`define VPI_VEC_SPI_CHANNEL_1_LO     6'h26
`define VPI_VEC_SERIAL1_LO  6'h2a
`define VPI_VEC_SERIAL1_HI  6'h2d
`define VPI_VEC_WDOG_RST    6'h01
`define VPI_VEC_DBG_STEP    6'h06
`define VPI_VEC_DBG_BRK     6'h07
`define VPI_VEC_DBG_TRACE   6'h09
`define VPI_VEC_DBG_TXE     6'h0a
`define VPI_VEC_DBG_RXF     6'h0b
`define VPI_VEC_EXT_A       6'h11
`define VPI_VEC_EXT_B       6'h12
`define VPI_VEC_LOW_VOLT    6'h14
`define VPI_VEC_CLK_SYNTH   6'h15
`define VPI_VEC_GPIO_LO     6'h1e
`define VPI_VEC_SPI_CHANNEL_0_LO     6'h28
`define VPI_VEC_QDEC1       6'h2f
`define VPI_ENTRY_SHIFT     1
`define VPI_VBA_RST         21'h000000

`endif

// [verilog/vpi_pkg.sv]
// types of the vectored priority interrupt block
// assumes: included map header supplies the numbers
`include "vpi_map.svh"
package vpi_pkg;
  typedef logic [1:0] vpi_level_t;
  typedef logic [5:0] vpi_vector_t;
  typedef enum logic [1:0] {
    VPI_IDLE  = 2'b01,
    VPI_OFFER = 2'b10
  } vpi_state_t;
endpackage
